// file: bench/host_write_data.sv
// host side model that presents write data to the sram
module host_write_data
  import sync_sram_pkg::*;
(
  // clock and request
  input  wire logic              i_clock,
  input  wire logic              i_put,
  input  wire logic [DATA_W-1:0] i_value,
  input  wire logic              i_pipelined,
  // data toward the device
  output logic      [DATA_W-1:0] o_data
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // write data delay line
  // ----------
  logic [1:0]        put_q = 2'h0;
  logic [DATA_W-1:0] val_q [0:1];
  logic [DATA_W-1:0] last = 36'h0;
  wire               drive = put_q[i_pipelined];
  always @(posedge i_clock) begin
    put_q <= {put_q[0], i_put};
    val_q[0] <= i_value;
    val_q[1] <= val_q[0];
    if (drive) last <= o_data;
  end
  // data at the second or third edge; inverted last value when released
  assign o_data = drive ? val_q[i_pipelined] : ~last;
endmodule

// file: bench/test_sync_burst_sram_command_control.sv
// self-checking bench of the sram command, burst and sleep control
module test_sync_burst_sram_command_control
  import sync_sram_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------
  // signals
  // ----------
  logic              i_clock = 1'h0;
  logic              i_reset = 1'h1;
  logic              i_clock_gate = 1'h0;
  logic              i_counter_step_or_load = 1'h0;
  logic              i_store_select_n = 1'h1;
  logic [LANES-1:0]  i_byte_lane_strobes_n = 4'hf;
  logic [2:0]        cs = 3'h7;
  logic [ADDR_W-1:0] i_address = 8'h00;
  logic [DATA_W-1:0] i_data;
  logic [DATA_W-1:0] o_data;
  logic              o_data_oe;
  logic              i_output_enable_n = 1'h0;
  logic              i_sleep_request = 1'h0;
  logic              i_burst_order_select = 1'h0;
  logic              i_output_register_select = 1'h1;
  logic              o_sleeping;
  logic              put = 1'h0;
  logic [DATA_W-1:0] put_val = 36'h0;
  logic [DATA_W-1:0] mem [0:MEM_DEPTH-1];
  logic              cmd_rd = 1'h0;
  logic              cmd_gate = 1'h0;
  logic [DATA_W-1:0] cmd_val = 36'h0;
  logic              smp_rd = 1'h0;
  logic              smp_gate = 1'h0;
  logic [DATA_W-1:0] smp_val = 36'h0;
  logic [2:0]        sh_rd = 3'h0;
  logic [DATA_W-1:0] sh_val [0:2];
  logic              chk_on = 1'h0;
  logic              oe_on = 1'h1;
  logic [ADDR_W-1:0] base;
  int                lat;
  int                n_errors = 0;
  int                check_count = 0;

  always #5 i_clock = ~i_clock;

  sram_command_control dut_u (
    .i_clock                  (i_clock),
    .i_reset                  (i_reset),
    .i_clock_enable           (1'h1),
    .i_clock_gate             (i_clock_gate),
    .i_counter_step_or_load   (i_counter_step_or_load),
    .i_store_select_n         (i_store_select_n),
    .i_byte_lane_strobes_n    (i_byte_lane_strobes_n),
    .i_chip_select_low_a_n    (cs[2]),
    .i_chip_select_high       (cs[1]),
    .i_chip_select_low_b_n    (cs[0]),
    .i_address                (i_address),
    .i_data                   (i_data),
    .o_data                   (o_data),
    .o_data_oe                (o_data_oe),
    .i_output_enable_n        (i_output_enable_n),
    .i_sleep_request          (i_sleep_request),
    .i_burst_order_select     (i_burst_order_select),
    .i_output_register_select (i_output_register_select),
    .o_sleeping               (o_sleeping)
  );

  host_write_data host_u (
    .i_clock     (i_clock),
    .i_put       (put),
    .i_value     (put_val),
    .i_pipelined (i_output_register_select),
    .o_data      (i_data)
  );

  // ----------
  // tasks
  // ----------
  task automatic wrap_up();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic check(input logic ok, input string m);
    check_count++;
    if (ok !== 1'h1) begin
      n_errors++;
      $display("Error at %0t: %s", $time, m);
    end
  endtask

  function automatic logic [7:0] nxt(input logic [7:0] a, input int k);
    logic [1:0] s;
    s = 2'(k);
    return {a[7:2], i_burst_order_select ? a[1:0] ^ s : a[1:0] + s};
  endfunction

  task automatic issue(input logic stp, input logic wr, input logic [3:0] ln,
      input logic [2:0] c, input logic [7:0] a, input logic g,
      input logic rd, input logic [35:0] d);
    @(posedge i_clock);
    i_counter_step_or_load <= stp;
    i_store_select_n <= ~wr;
    i_byte_lane_strobes_n <= ln;
    cs <= c;
    i_address <= a;
    i_clock_gate <= g;
    put <= wr & ~g;
    put_val <= d;
    cmd_rd <= rd;
    cmd_gate <= g;
    cmd_val <= d;
    #1;
  endtask

  task automatic idle();
    issue(1'h0, 1'h0, 4'hf, 3'h7, 8'h00, 1'h0, 1'h0, 36'h0);
  endtask

  task automatic burst(input logic wr, input logic [7:0] a, input int n);
    logic [7:0]  ad;
    logic [35:0] d;
    for (int k = 0; k < n; k++) begin
      ad = nxt(a, k);
      d = wr ? {20'h3c5a0, 8'(k), ad} : mem[ad];
      if (wr) mem[ad] = d;
      if (!wr && k == 2) issue(1'h1, 1'h0, 4'hf, 3'h7, a, 1'h1, 1'h0, 36'h0);
      issue(k > 0, wr, 4'h0, k > 0 ? 3'h7 : 3'h2, a, 1'h0, !wr, d);
    end
  endtask

  task automatic do_reset(input logic pipe, input logic order);
    @(posedge i_clock);
    chk_on = 1'h0;
    i_reset <= 1'h1;
    i_output_register_select <= pipe;
    i_burst_order_select <= order;
    repeat (10) @(posedge i_clock);
    check(o_data_oe === 1'h0 && o_sleeping === 1'h0, "reset");
    i_reset <= 1'h0;
    repeat (3) idle();
    chk_on = 1'h1;
  endtask

  task automatic wait_sleep(input logic lvl);
    int n;
    n = 0;
    while (o_sleeping !== lvl && n < 8) begin
      idle();
      n++;
    end
    check(n == (lvl ? SLEEP_ENTRY_CYCLES : WAKE_CYCLES) + 2,
      "sleep timing");
    if (n == 8) wrap_up();
  endtask

  // ----------
  // read pipeline observer
  // ----------
  always @(posedge i_clock) begin
    smp_rd <= cmd_rd;
    smp_gate <= cmd_gate;
    smp_val <= cmd_val;
  end

  always @(negedge i_clock) begin
    if (!chk_on) begin
      sh_rd = 3'h0;
    end else begin
      if (!smp_gate) begin
        sh_rd = {sh_rd[1:0], smp_rd};
        sh_val[2] = sh_val[1];
        sh_val[1] = sh_val[0];
        sh_val[0] = smp_val;
      end
      lat = 1 + int'(i_output_register_select);
      check(o_data_oe === (sh_rd[lat] & oe_on), "drive");
      if (sh_rd[lat] & oe_on) begin
        check(o_data === sh_val[lat], "read data");
      end
    end
  end

  // ----------
  // test sequence
  // ----------
  initial begin
    for (int c = 0; c < 4; c++) begin
      do_reset(c[1], c[0]);
      base = {6'(c + 1), 2'(c + 1)};
      burst(1'h1, base, 4);
      mem[base][8:0] = 9'h1a5;
      issue(1'h1, 1'h1, 4'he, 3'h7, base, 1'h0, 1'h0, {27'h0, 9'h1a5});
      repeat (3) idle();
      burst(1'h0, base, 5);
      repeat (3) idle();
    end
    issue(1'h0, 1'h1, 4'hf, 3'h2, base, 1'h0, 1'h0, 36'h0);
    repeat (3) idle();
    burst(1'h0, base, 1);
    foreach (sh_val[i]) begin
      issue(1'h0, 1'h0, 4'hf, 3'(7 >> i), base, 1'h0, 1'h0, 36'h0);
      issue(1'h1, 1'h0, 4'hf, 3'h2, base, 1'h0, 1'h0, 36'h0);
    end
    @(posedge i_clock);
    i_output_enable_n <= 1'h1;
    oe_on = 1'h0;
    repeat (3) idle();
    burst(1'h0, base, 2);
    repeat (4) idle();
    @(posedge i_clock);
    i_output_enable_n <= 1'h0;
    oe_on = 1'h1;
    @(posedge i_clock);
    i_sleep_request <= 1'h1;
    wait_sleep(1'h1);
    issue(1'h0, 1'h1, 4'h0, 3'h2, base, 1'h0, 1'h0, 36'h0);
    @(posedge i_clock);
    i_sleep_request <= 1'h0;
    wait_sleep(1'h0);
    burst(1'h0, base, 1);
    repeat (3) idle();
    wrap_up();
  end
endmodule

// file: logic/burst_address_counter.sv
// two-bit burst counter with linear and interleaved order
module burst_address_counter
  import sync_sram_pkg::*;
(
  // clock and reset
  input  wire logic             i_clock,
  input  wire logic             i_reset,
  // control
  input  wire logic             i_advance,
  input  wire logic             i_load,
  input  wire logic             i_step,
  input  wire logic             i_interleave,
  input  wire logic [LOW_W-1:0] i_load_low,
  // status
  output logic      [LOW_W-1:0] o_access_low,
  output logic      [LOW_W-1:0] o_base,
  output logic      [LOW_W-1:0] o_count
);

  logic [LOW_W-1:0] next_base;
  logic [LOW_W-1:0] next_count;

  // ---------------------------------------------------------------
  // next address
  // ---------------------------------------------------------------
  always_comb begin
    next_base  = o_base;
    next_count = o_count;
    if (i_load) begin
      next_base  = i_load_low;
      next_count = LOW_RESET;
    end else if (i_step) begin
      next_count = LOW_W'(o_count + 2'h1);
    end
    if (i_interleave) begin
      o_access_low = next_base ^ next_count;
    end else begin
      o_access_low = LOW_W'(next_base + next_count);
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_base  <= LOW_RESET;
      o_count <= LOW_RESET;
    end else if (i_advance) begin
      o_base  <= next_base;
      o_count <= next_count;
    end
  end

endmodule

// file: logic/sram_command_control.sv
// command decode, burst, output drive and sleep control of the sram
module sram_command_control
  import sync_sram_pkg::*;
(
  // clock and reset
  input  wire logic              i_clock,
  input  wire logic              i_reset,
  input  wire logic              i_clock_enable,
  // synchronous host commands
  input  wire logic              i_clock_gate,
  input  wire logic              i_counter_step_or_load,
  input  wire logic              i_store_select_n,
  input  wire logic [LANES-1:0]  i_byte_lane_strobes_n,
  input  wire logic              i_chip_select_low_a_n,
  input  wire logic              i_chip_select_high,
  input  wire logic              i_chip_select_low_b_n,
  input  wire logic [ADDR_W-1:0] i_address,
  // data bus
  input  wire logic [DATA_W-1:0] i_data,
  output logic      [DATA_W-1:0] o_data,
  output logic                   o_data_oe,
  // asynchronous inputs
  input  wire logic              i_output_enable_n,
  input  wire logic              i_sleep_request,
  // static configuration
  input  wire logic              i_burst_order_select,
  input  wire logic              i_output_register_select,
  // status
  output logic                   o_sleeping
);

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic              oe_n_meta;
  logic              oe_n_sync;
  logic              sleep_meta;
  logic              sleep_sync;
  sleep_state_t      state;
  sleep_state_t      next_state;
  logic [SLEEP_COUNT_W-1:0] sleep_count;
  logic [SLEEP_COUNT_W-1:0] next_sleep_count;
  logic              awake;
  logic              cmd_go;
  logic              pipelined;
  logic              is_load;
  logic              is_step;
  logic              selected;
  logic              begin_read;
  logic              begin_write;
  logic              cont_access;
  logic              burst_active;
  logic              burst_write;
  logic [UPPER_W-1:0] upper;
  logic [LOW_W-1:0]  access_low;
  logic [LOW_W-1:0]  burst_base;
  logic [LOW_W-1:0]  burst_count;
  access_t           next_access;
  access_t           stage1;
  access_t           stage2;
  access_t           write_stage;
  logic [DATA_W-1:0] read_data;
  logic [DATA_W-1:0] read_hold;
  logic              drive;
  logic              next_drive;

  // ---------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------
  function automatic logic any_lane(input logic [LANES-1:0] strobes_n);
    any_lane = |(~strobes_n);
  endfunction

  function automatic logic is_read(input access_t acc);
    is_read = acc.valid && !acc.write;
  endfunction

  // ---------------------------------------------------------------
  // asynchronous input synchronisers
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      oe_n_meta <= OE_N_RESET;
      oe_n_sync <= OE_N_RESET;
    end else if (i_clock_enable) begin
      oe_n_meta <= i_output_enable_n;
      oe_n_sync <= oe_n_meta;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      sleep_meta <= SLEEP_RESET;
      sleep_sync <= SLEEP_RESET;
    end else if (i_clock_enable) begin
      sleep_meta <= i_sleep_request;
      sleep_sync <= sleep_meta;
    end
  end

  // ---------------------------------------------------------------
  // sleep state machine
  // ---------------------------------------------------------------
  always_comb begin
    next_state       = state;
    next_sleep_count = sleep_count;
    case (state)
      st_awake: begin
        if (sleep_sync) begin
          next_state       = st_entering;
          next_sleep_count = COUNT_RESET;
        end
      end
      st_entering: begin
        if (!sleep_sync) begin
          next_state = st_awake;
        end else if (sleep_count == ENTRY_LAST) begin
          next_state = st_asleep;
        end else begin
          next_sleep_count = SLEEP_COUNT_W'(sleep_count + 2'h1);
        end
      end
      st_asleep: begin
        if (!sleep_sync) begin
          next_state       = st_waking;
          next_sleep_count = COUNT_RESET;
        end
      end
      st_waking: begin
        if (sleep_sync) begin
          next_state = st_asleep;
        end else if (sleep_count == WAKE_LAST) begin
          next_state = st_awake;
        end else begin
          next_sleep_count = SLEEP_COUNT_W'(sleep_count + 2'h1);
        end
      end
      default: begin
        next_state = st_awake;
      end
    endcase
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      state       <= st_awake;
      sleep_count <= COUNT_RESET;
    end else if (i_clock_enable) begin
      state       <= next_state;
      sleep_count <= next_sleep_count;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_sleeping <= 1'b0;
    end else if (i_clock_enable) begin
      o_sleeping <= (next_state == st_asleep) ||
                    (next_state == st_waking);
    end
  end

  // ---------------------------------------------------------------
  // command decode
  // ---------------------------------------------------------------
  assign awake     = (state == st_awake) || (state == st_entering);
  assign cmd_go    = i_clock_enable && !i_clock_gate && awake;
  assign pipelined = i_output_register_select;
  assign is_load   = !i_counter_step_or_load;
  assign is_step   = i_counter_step_or_load;
  assign selected  = !i_chip_select_low_a_n && i_chip_select_high &&
                     !i_chip_select_low_b_n;
  assign begin_read  = is_load && selected && i_store_select_n;
  assign begin_write = is_load && selected && !i_store_select_n &&
                       any_lane(i_byte_lane_strobes_n);
  assign cont_access = is_step && burst_active;

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      burst_active <= 1'b0;
      burst_write  <= 1'b0;
    end else if (cmd_go) begin
      if (begin_read || begin_write) begin
        burst_active <= 1'b1;
        burst_write  <= begin_write;
      end else if (is_load) begin
        burst_active <= 1'b0;
      end
    end
  end

  // ---------------------------------------------------------------
  // burst address generation
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      upper <= UPPER_RESET;
    end else if (cmd_go && (begin_read || begin_write)) begin
      upper <= i_address[ADDR_W-1:LOW_W];
    end
  end

  burst_address_counter counter (
    .i_clock      (i_clock),
    .i_reset      (i_reset),
    .i_advance    (cmd_go),
    .i_load       (begin_read || begin_write),
    .i_step       (cont_access),
    .i_interleave (i_burst_order_select),
    .i_load_low   (i_address[LOW_W-1:0]),
    .o_access_low (access_low),
    .o_base       (burst_base),
    .o_count      (burst_count)
  );

  always_comb begin
    next_access       = ACCESS_RESET;
    next_access.valid = begin_read || begin_write || cont_access;
    next_access.write = begin_write || (cont_access && burst_write);
    next_access.lanes = ~i_byte_lane_strobes_n;
    if (begin_read || begin_write) begin
      next_access.addr = {i_address[ADDR_W-1:LOW_W], access_low};
    end else begin
      next_access.addr = {upper, access_low};
    end
  end

  // ---------------------------------------------------------------
  // access pipeline
  // ---------------------------------------------------------------
  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      stage1 <= ACCESS_RESET;
      stage2 <= ACCESS_RESET;
    end else if (cmd_go) begin
      stage1 <= next_access;
      stage2 <= stage1;
    end
  end

  // write data one edge after the command in flow-through, two in pipelined
  assign write_stage = pipelined ? stage2 : stage1;

  // a read right behind a write to the same word sees the old contents
  sram_core_memory core (
    .i_clock         (i_clock),
    .i_read_enable   (cmd_go && is_read(next_access)),
    .i_read_address  (next_access.addr),
    .o_read_data     (read_data),
    .i_write_enable  (cmd_go && write_stage.valid && write_stage.write),
    .i_write_address (write_stage.addr),
    .i_write_lanes   (write_stage.lanes),
    .i_write_data    (i_data)
  );

  // ---------------------------------------------------------------
  // read data and output drive
  // ---------------------------------------------------------------
  assign next_drive = pipelined ? is_read(stage2) : is_read(stage1);

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      read_hold <= DATA_RESET;
      o_data    <= DATA_RESET;
    end else if (cmd_go) begin
      read_hold <= read_data;
      o_data    <= pipelined ? read_hold : read_data;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      drive <= 1'b0;
    end else if (cmd_go) begin
      drive <= next_drive;
    end
  end

  always_ff @(posedge i_clock or posedge i_reset) begin
    if (i_reset) begin
      o_data_oe <= 1'b0;
    end else if (i_clock_enable) begin
      if (!awake) begin
        o_data_oe <= 1'b0;
      end else if (cmd_go) begin
        o_data_oe <= next_drive && !oe_n_sync;
      end else begin
        o_data_oe <= drive && !oe_n_sync;
      end
    end
  end

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  read_begin_a: assert property (
    cmd_go && begin_read |=> stage1.valid && !stage1.write &&
      stage1.addr == $past(i_address))
    else $error("read begin not loaded");

  write_begin_a: assert property (
    cmd_go && begin_write |=> stage1.valid && stage1.write &&
      stage1.lanes == ~$past(i_byte_lane_strobes_n))
    else $error("write begin not loaded");

  write_abort_a: assert property (
    cmd_go && is_load && selected && !i_store_select_n &&
      !any_lane(i_byte_lane_strobes_n) |=> !stage1.valid && !burst_active)
    else $error("write abort started an access");

  deselect_cycle_a: assert property (
    cmd_go && is_load && !selected ##1 cmd_go
      |-> !stage1.valid && !burst_active ##1
        (pipelined ? !is_read(stage2) : !o_data_oe))
    else $error("deselect left an access");

  stall_hold_a: assert property (
    i_clock_enable && i_clock_gate && awake
      |=> $stable(stage1) && $stable(stage2) && $stable(o_data))
    else $error("state moved under clock gate");

  drive_off_a: assert property (
    i_clock_enable && oe_n_sync |=> !o_data_oe)
    else $error("outputs driven while disabled");

  linear_step_a: assert property (
    cmd_go && cont_access && !i_burst_order_select
      |=> stage1.addr[1:0] == 2'($past(stage1.addr[1:0]) + 2'h1))
    else $error("linear burst step wrong");

  interleave_step_a: assert property (
    cmd_go && cont_access && i_burst_order_select
      |=> stage1.addr[1:0] == (burst_base ^ burst_count))
    else $error("interleaved burst step wrong");

  burst_wrap_a: assert property (
    cmd_go && (begin_read || begin_write) ##1
      (cmd_go && cont_access && !begin_read && !begin_write) [*4]
      |=> stage1.addr[1:0] == burst_base && burst_count == 2'h0)
    else $error("burst did not wrap");

  sleep_entry_a: assert property (
    state == st_awake && sleep_sync && i_clock_enable ##1
      (sleep_sync && i_clock_enable) |=> state == st_asleep && o_sleeping)
    else $error("sleep not entered after two cycles");

  wake_up_a: assert property (
    state == st_asleep && !sleep_sync && i_clock_enable ##1
      (!sleep_sync && i_clock_enable) |=> state == st_awake && !o_sleeping)
    else $error("wake not complete after two cycles");

  sleep_quiet_a: assert property (
    !awake |=> !o_data_oe && $stable(stage1))
    else $error("activity while asleep");

  pipe_read_a: assert property (
    cmd_go && begin_read && pipelined ##1 cmd_go ##1
      (cmd_go && !oe_n_sync && pipelined) |=> o_data_oe)
    else $error("pipelined read not driven");

  flow_read_a: assert property (
    cmd_go && begin_read && !pipelined ##1
      (cmd_go && !oe_n_sync && !pipelined)
      |=> o_data_oe && o_data == $past(read_data))
    else $error("flow-through read not driven");

endmodule

// file: logic/sram_core_memory.sv
// byte-lane storage array with a registered read port
module sram_core_memory
  import sync_sram_pkg::*;
(
  // clock
  input  wire logic              i_clock,
  // read port
  input  wire logic              i_read_enable,
  input  wire logic [ADDR_W-1:0] i_read_address,
  output wire logic [DATA_W-1:0] o_read_data,
  // write port
  input  wire logic              i_write_enable,
  input  wire logic [ADDR_W-1:0] i_write_address,
  input  wire logic [LANES-1:0]  i_write_lanes,
  input  wire logic [DATA_W-1:0] i_write_data
);

  // ---------------------------------------------------------------
  // one array per byte lane
  // ---------------------------------------------------------------
  for (genvar g = 0; g < LANES; g++) begin : lane
    logic [LANE_W-1:0] store [MEM_DEPTH];
    logic [LANE_W-1:0] read_q;

    always_ff @(posedge i_clock) begin
      if (i_write_enable && i_write_lanes[g]) begin
        store[i_write_address] <= i_write_data[g*LANE_W +: LANE_W];
      end
    end

    always_ff @(posedge i_clock) begin
      if (i_read_enable) begin
        read_q <= store[i_read_address];
      end
    end

    assign o_read_data[g*LANE_W +: LANE_W] = read_q;
  end

endmodule

// file: logic/sync_sram_pkg.sv
// shared constants, types and states of the synchronous sram control block
package sync_sram_pkg;

  // ---------------------------------------------------------------
  // widths and sizes
  // ---------------------------------------------------------------
  localparam int ADDR_W    = 8;
  localparam int LANES     = 4;
  localparam int LANE_W    = 9;
  localparam int DATA_W    = LANES * LANE_W;
  localparam int MEM_DEPTH = 1 << ADDR_W;
  localparam int LOW_W     = 2;
  localparam int UPPER_W   = ADDR_W - LOW_W;

  // ---------------------------------------------------------------
  // sleep timing in clock cycles
  // ---------------------------------------------------------------
  localparam int SLEEP_ENTRY_CYCLES = 2;
  localparam int WAKE_CYCLES        = 2;
  localparam int SLEEP_COUNT_W      = 2;
  localparam logic [SLEEP_COUNT_W-1:0] ENTRY_LAST =
    SLEEP_COUNT_W'(SLEEP_ENTRY_CYCLES - 2);
  localparam logic [SLEEP_COUNT_W-1:0] WAKE_LAST =
    SLEEP_COUNT_W'(WAKE_CYCLES - 2);

  // ---------------------------------------------------------------
  // values after reset
  // ---------------------------------------------------------------
  localparam logic [LOW_W-1:0]   LOW_RESET    = 2'h0;
  localparam logic [UPPER_W-1:0] UPPER_RESET  = 6'h00;
  localparam logic               OE_N_RESET   = 1'h1;
  localparam logic               SLEEP_RESET  = 1'h0;
  localparam logic [DATA_W-1:0]  DATA_RESET   = 36'h0;
  localparam logic [SLEEP_COUNT_W-1:0] COUNT_RESET = 2'h0;

  // ---------------------------------------------------------------
  // types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic              valid;
    logic              write;
    logic [LANES-1:0]  lanes;
    logic [ADDR_W-1:0] addr;
  } access_t;

  localparam access_t ACCESS_RESET = '{1'b0, 1'b0, 4'h0, 8'h00};

  typedef enum logic [3:0] {
    st_awake    = 4'b0001,
    st_entering = 4'b0010,
    st_asleep   = 4'b0100,
    st_waking   = 4'b1000
  } sleep_state_t;

endpackage
